/* File: qlt_transmitter.sv */
// Register port, clock divider, transport, scrambler and 8b/10b link layer of the transmitter.
`timescale 1ns/10ps

module qlt_transmitter (
  input  wire logic                         clock,
  input  wire logic                         sys_rst,
  input  wire logic                         serial_enable_n,
  input  wire logic                         serial_clock,
  input  wire logic                         serial_data_in,
  output logic                              serial_data_out,
  output logic                              serial_data_out_oe,
  input  wire logic                         power_down_pin,
  input  wire logic                         sync_request,
  input  wire logic                         sysref,
  input  wire logic [qlt_pkg::CHANNELS-1:0][11:0] sample_in,
  output logic                              sample_tick,
  output logic                              frame_tick,
  output logic [qlt_pkg::CHANNELS-1:0][19:0] lane_code,
  output logic                              lane_code_valid,
  output logic                              global_power_down,
  output logic                              standby,
  output logic [qlt_pkg::CHANNELS-1:0]      channel_dither_off,
  output logic [3:0]                        lane_drive_current
);

  // ------------------------------------------------------------------------
  // Encoding helpers
  // ------------------------------------------------------------------------
  function automatic logic [10:0] encode_8b10b(input logic [7:0] d, input logic k,
                                               input logic rd);
    logic [5:0] six;
    logic [3:0] four;
    logic       rd_mid;
    six = 6'h00;
    four = 4'h0;
    case (d[4:0])
      5'd0: six = 6'b100111;  5'd1: six = 6'b011101;  5'd2: six = 6'b101101;
      5'd3: six = 6'b110001;  5'd4: six = 6'b110101;  5'd5: six = 6'b101001;
      5'd6: six = 6'b011001;  5'd7: six = 6'b111000;  5'd8: six = 6'b111001;
      5'd9: six = 6'b100101;  5'd10: six = 6'b010101; 5'd11: six = 6'b110100;
      5'd12: six = 6'b001101; 5'd13: six = 6'b101100; 5'd14: six = 6'b011100;
      5'd15: six = 6'b010111; 5'd16: six = 6'b011011; 5'd17: six = 6'b100011;
      5'd18: six = 6'b010011; 5'd19: six = 6'b110010; 5'd20: six = 6'b001011;
      5'd21: six = 6'b101010; 5'd22: six = 6'b011010; 5'd23: six = 6'b111010;
      5'd24: six = 6'b110011; 5'd25: six = 6'b100110; 5'd26: six = 6'b010110;
      5'd27: six = 6'b110110; 5'd28: six = 6'b001110; 5'd29: six = 6'b101110;
      5'd30: six = 6'b011110; default: six = 6'b101011;
    endcase
    if (k) six = 6'b001111;
    if (rd && ($countones(six) != 3 || six == 6'b111000)) six = ~six;
    rd_mid = rd ^ ($countones(six) != 3);
    case (d[7:5])
      3'd0: four = 4'b1011;  3'd1: four = 4'b1001;  3'd2: four = 4'b0101;
      3'd3: four = 4'b1100;  3'd4: four = 4'b1101;  3'd5: four = 4'b1010;
      3'd6: four = 4'b0110;  default: four = 4'b1110;
    endcase
    if (!k && d[7:5] == 3'd7 && ((!rd_mid && (d[4:0] == 5'd17 || d[4:0] == 5'd18 ||
        d[4:0] == 5'd20)) || (rd_mid && (d[4:0] == 5'd11 || d[4:0] == 5'd13 ||
        d[4:0] == 5'd14)))) four = 4'b0111;
    if (rd_mid && ($countones(four) != 2 || four == 4'b1100)) four = ~four;
    else if (k && !rd_mid && $countones(four) == 2 && four != 4'b1100) four = ~four;
    return {rd_mid ^ ($countones(four) != 2), six, four};
  endfunction : encode_8b10b

  // Self-synchronous scrambler 1 + x^14 + x^15, most significant bit first.
  function automatic logic [22:0] scramble(input logic [7:0] d, input logic [14:0] s);
    logic [14:0] st;
    logic [7:0]  o;
    st = s;
    o = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      o[b] = d[b] ^ st[14] ^ st[13];
      st = {st[13:0], o[b]};
    end
    return {st, o};
  endfunction : scramble

  // PRBS 2^15-1, sixteen bit steps per frame.
  function automatic logic [30:0] prbs_frame(input logic [14:0] s);
    logic [14:0] st;
    logic [15:0] bits;
    st = s;
    bits = 16'h0000;
    for (int b = 15; b >= 0; b--) begin
      bits[b] = st[14] ^ st[13];
      st = {st[13:0], bits[b]};
    end
    return {st, bits};
  endfunction : prbs_frame

  // ------------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------------
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic       sclk_last;
  logic       sync_last;
  logic       sysref_last;
  always_ff @(posedge clock) begin
    pin_meta <= {serial_enable_n, serial_clock, serial_data_in, power_down_pin,
                 sync_request, sysref};
    pin_sync <= pin_meta;
    sclk_last <= pin_sync[4];
    sync_last <= pin_sync[1];
    sysref_last <= pin_sync[0];
  end
  wire sen_n_s  = pin_sync[5];
  wire sclk_s   = pin_sync[4];
  wire sdata_s  = pin_sync[3];
  wire pdn_s    = pin_sync[2];
  wire sync_s   = pin_sync[1];
  wire sysref_s = pin_sync[0];

  // ------------------------------------------------------------------------
  // Serial register port
  // ------------------------------------------------------------------------
  logic [4:0]  bit_count;
  logic [22:0] shift_in;
  logic [7:0]  read_shift;
  logic        reg_power_down_7;
  logic [7:0]  power_down_control;
  logic [7:0]  link_test_pattern_select;
  qlt_pkg::qlt_link_cfg_type link_config;
  logic [4:0]  frames_m1;
  logic [3:0]  dither_off;
  logic [3:0]  drive;
  qlt_pkg::qlt_link_state_type state;
  wire  [23:0] word  = {shift_in, sdata_s};
  wire         sclk_rise = sclk_s && !sclk_last && !sen_n_s;
  wire         sclk_fall = !sclk_s && sclk_last && !sen_n_s;
  wire         write_en  = sclk_rise && bit_count == qlt_pkg::SERIAL_LAST_BIT &&
                           !word[23] && word[22];
  wire         read_go   = sclk_rise && bit_count == qlt_pkg::SERIAL_ADDR_END &&
                           word[15] && word[14];
  wire  [13:0] read_addr = word[13:0];
  logic [7:0]  read_word;

  always_comb begin
    case (read_addr)
      qlt_pkg::ADDR_POWER_DOWN:    read_word = power_down_control;
      qlt_pkg::ADDR_TEST_PATTERN:  read_word = link_test_pattern_select;
      qlt_pkg::ADDR_LINK_CONFIG:   read_word = link_config;
      qlt_pkg::ADDR_FRAMES_PER_MF: read_word = {3'h0, frames_m1};
      qlt_pkg::ADDR_DITHER_OFF:    read_word = {4'h0, dither_off};
      qlt_pkg::ADDR_DRIVE:         read_word = {4'h0, drive};
      qlt_pkg::ADDR_LINK_STATUS:   read_word = {5'h00, sync_s, 2'(state)};
      default:                     read_word = 8'h00;
    endcase
  end

  // Words beyond a whole multiple of 24 bits are dropped when enable rises.
  always_ff @(posedge clock) begin
    if (sys_rst || sen_n_s) begin
      bit_count <= 5'h00;
      shift_in  <= 23'h000000;
    end else if (sclk_rise) begin
      shift_in  <= word[22:0];
      bit_count <= (bit_count == qlt_pkg::SERIAL_LAST_BIT) ? 5'h00 : bit_count + 5'h01;
    end
  end

  // Read data leaves on falling clock edges so the controller samples on rising ones.
  always_ff @(posedge clock) begin
    if (sys_rst || sen_n_s) begin
      serial_data_out_oe <= 1'b0;
      serial_data_out    <= 1'b0;
      read_shift         <= 8'h00;
    end else if (read_go) begin
      serial_data_out_oe <= 1'b1;
      read_shift         <= read_word;
    end else if (sclk_fall && serial_data_out_oe) begin
      serial_data_out <= read_shift[7];
      read_shift      <= {read_shift[6:0], 1'b0};
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      power_down_control       <= qlt_pkg::POWER_DOWN_RESET;
      link_test_pattern_select <= qlt_pkg::TEST_PATTERN_RESET;
      link_config              <= qlt_pkg::LINK_CONFIG_RESET;
      frames_m1                <= qlt_pkg::FRAMES_M1_RESET;
      dither_off               <= qlt_pkg::DITHER_OFF_RESET;
      drive                    <= qlt_pkg::DRIVE_RESET;
    end else if (write_en) begin
      case (word[21:8])
        qlt_pkg::ADDR_POWER_DOWN:    power_down_control <= word[7:0];
        qlt_pkg::ADDR_TEST_PATTERN:  link_test_pattern_select <= word[7:0];
        qlt_pkg::ADDR_LINK_CONFIG:   link_config <= word[7:0];
        qlt_pkg::ADDR_FRAMES_PER_MF: frames_m1 <= word[4:0];
        qlt_pkg::ADDR_DITHER_OFF:    dither_off <= word[3:0];
        qlt_pkg::ADDR_DRIVE:         drive <= word[3:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------------
  // Power, dither and drive controls
  // ------------------------------------------------------------------------
  wire pin_is_standby = power_down_control[qlt_pkg::PD_PIN_STANDBY_BIT];
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      global_power_down <= 1'b0;
      standby           <= 1'b0;
    end else begin
      global_power_down <= power_down_control[qlt_pkg::PD_GLOBAL_BIT] ||
                           (pdn_s && !pin_is_standby);
      standby           <= power_down_control[qlt_pkg::PD_STANDBY_BIT] ||
                           (pdn_s && pin_is_standby);
    end
  end
  // Drive code n gives 5 mA plus n mA; codes above 15 do not exist, so 20 mA is the top.
  assign channel_dither_off = dither_off;
  assign lane_drive_current = drive;

  // ------------------------------------------------------------------------
  // Clock divider and frame timing
  // ------------------------------------------------------------------------
  logic [1:0] div_count;
  logic       half;
  wire div_end = (link_config.div_sel == qlt_pkg::DIV_BY_1) ||
                 (link_config.div_sel == qlt_pkg::DIV_BY_2 && div_count[0]) ||
                 (div_count == 2'h3);
  always_ff @(posedge clock) begin
    if (sys_rst || div_end) div_count <= 2'h0;
    else div_count <= div_count + 2'h1;
  end
  always_ff @(posedge clock) begin
    if (sys_rst) half <= 1'b0;
    else if (div_end) half <= link_config.mode40 && !half;
  end
  // In 40x mode a sample slot spans two frames: with the data pattern selected the second carries all zeros.
  wire sample_phase = !link_config.mode40 || !half;
  assign frame_tick  = div_end;
  assign sample_tick = div_end && sample_phase;

  // ------------------------------------------------------------------------
  // Multiframe clock and link sequencing
  // ------------------------------------------------------------------------
  logic [4:0] frame_idx;
  logic [1:0] mf_idx;
  wire lmfc_end = frame_tick && frame_idx == frames_m1;
  wire realign  = (link_config.subclass == 2'h1 && sysref_s && !sysref_last) ||
                  (link_config.subclass == 2'h2 && sync_s && !sync_last);
  always_ff @(posedge clock) begin
    if (sys_rst || realign) frame_idx <= 5'h00;
    else if (lmfc_end) frame_idx <= 5'h00;
    else if (frame_tick) frame_idx <= frame_idx + 5'h01;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state  <= qlt_pkg::LINK_COMMA;
      mf_idx <= 2'h0;
    end else if (sync_s) begin
      state  <= qlt_pkg::LINK_COMMA;
      mf_idx <= 2'h0;
    end else begin
      case (state)
        qlt_pkg::LINK_COMMA: state <= qlt_pkg::LINK_WAIT_LMFC;
        qlt_pkg::LINK_WAIT_LMFC: if (lmfc_end) state <= qlt_pkg::LINK_ALIGN;
        qlt_pkg::LINK_ALIGN: begin
          if (lmfc_end) begin
            mf_idx <= mf_idx + 2'h1;
            if (mf_idx == qlt_pkg::ALIGN_LAST_MF) state <= qlt_pkg::LINK_DATA;
          end
        end
        qlt_pkg::LINK_DATA: state <= qlt_pkg::LINK_DATA;
        default: state <= qlt_pkg::LINK_COMMA;
      endcase
    end
  end

  // ------------------------------------------------------------------------
  // Shared test pattern sources
  // ------------------------------------------------------------------------
  logic [14:0] prbs_state;
  logic [7:0]  ramp;
  wire  [30:0] prbs_out = prbs_frame(prbs_state);
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prbs_state <= qlt_pkg::PRBS_SEED;
      ramp       <= 8'h00;
    end else if (frame_tick) begin
      prbs_state <= prbs_out[30:16];
      ramp       <= ramp + 8'h02;
    end
  end

  // ------------------------------------------------------------------------
  // Per-lane transport, scrambler and encoder
  // ------------------------------------------------------------------------
  wire [1:0] pattern = link_test_pattern_select[qlt_pkg::PATTERN_MSB:qlt_pkg::PATTERN_LSB];
  wire       cfg_frame = mf_idx == qlt_pkg::CONFIG_MF && frame_idx == 5'h01;
  always_ff @(posedge clock) begin
    if (sys_rst) lane_code_valid <= 1'b0;
    else lane_code_valid <= frame_tick && !global_power_down;
  end

  for (genvar ch = 0; ch < qlt_pkg::CHANNELS; ch++) begin : g_lane
    logic [15:0]  payload;
    logic [14:0]  scr_state;
    logic         rd;
    qlt_pkg::qlt_symbol_type sym0;
    qlt_pkg::qlt_symbol_type sym1;
    logic [22:0]  scr0;
    logic [22:0]  scr1;
    logic [10:0]  enc0;
    logic [10:0]  enc1;

    always_comb begin
      case (pattern)
        qlt_pkg::PATTERN_CLOCK:   payload = {qlt_pkg::CLOCK_OCTET, qlt_pkg::CLOCK_OCTET};
        qlt_pkg::PATTERN_ENCODED: payload = {ramp, ramp + 8'h01};
        qlt_pkg::PATTERN_PRBS:    payload = prbs_out[15:0];
        default: payload = sample_phase ? {sample_in[ch], 4'h0} : 16'h0000;
      endcase
      scr0 = scramble(payload[15:8], scr_state);
      scr1 = scramble(payload[7:0], scr0[22:8]);
      case (state)
        qlt_pkg::LINK_DATA: begin
          sym0 = {1'b0, link_config.scramble_en ? scr0[7:0] : payload[15:8]};
          sym1 = {1'b0, link_config.scramble_en ? scr1[7:0] : payload[7:0]};
        end
        qlt_pkg::LINK_ALIGN: begin
          sym0 = (frame_idx == 5'h00) ? {1'b1, qlt_pkg::K28_0} :
                 cfg_frame ? {1'b1, qlt_pkg::K28_4} : {1'b0, 3'h0, frame_idx};
          sym1 = (frame_idx == frames_m1) ? {1'b1, qlt_pkg::K28_3} :
                 cfg_frame ? {1'b0, 3'h0, frames_m1} : {1'b0, 3'h0, frame_idx};
        end
        default: begin
          sym0 = {1'b1, qlt_pkg::K28_5};
          sym1 = {1'b1, qlt_pkg::K28_5};
        end
      endcase
      enc0 = encode_8b10b(sym0.octet, sym0.is_k, rd);
      enc1 = encode_8b10b(sym1.octet, sym1.is_k, enc0[10]);
    end

    always_ff @(posedge clock) begin
      if (sys_rst) begin
        rd            <= 1'b0;
        scr_state     <= qlt_pkg::SCRAMBLE_SEED;
        lane_code[ch] <= 20'h00000;
      end else if (global_power_down) begin
        lane_code[ch] <= 20'h00000;
      end else if (frame_tick) begin
        rd            <= enc1[10];
        lane_code[ch] <= {enc0[9:0], enc1[9:0]};
        if (state == qlt_pkg::LINK_DATA && link_config.scramble_en) scr_state <= scr1[22:8];
      end
    end
  end

  // ------------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------------
  logic [7:0] align_frames;
  always_ff @(posedge clock) begin
    if (sys_rst || state != qlt_pkg::LINK_ALIGN) align_frames <= 8'h00;
    else if (frame_tick) align_frames <= align_frames + 8'h01;
  end

  // The state answers a request one clock late, so its first frame is not yet a comma.
  property p_comma_while_sync;
    @(posedge clock) disable iff (sys_rst)
      sync_s && $past(sync_s) && frame_tick && !global_power_down |=>
        lane_code[0][19:10] inside {10'b0011111010, 10'b1100000101};
  endproperty
  a_comma_while_sync: assert property (p_comma_while_sync) else $error("comma missing");

  property p_sync_to_comma;
    @(posedge clock) disable iff (sys_rst) sync_s |=> state == qlt_pkg::LINK_COMMA;
  endproperty
  a_sync_to_comma: assert property (p_sync_to_comma) else $error("sync ignored");

  property p_wait_boundary;
    @(posedge clock) disable iff (sys_rst)
      state == qlt_pkg::LINK_WAIT_LMFC && !lmfc_end |=> state != qlt_pkg::LINK_ALIGN;
  endproperty
  a_wait_boundary: assert property (p_wait_boundary) else $error("early align");

  property p_align_length;
    @(posedge clock) disable iff (sys_rst)
      state == qlt_pkg::LINK_ALIGN ##1 state == qlt_pkg::LINK_DATA |->
        $past(align_frames) == 8'(4 * (frames_m1 + 5'h01) - 1);
  endproperty
  a_align_length: assert property (p_align_length) else $error("align length wrong");

  property p_div4;
    @(posedge clock) disable iff (sys_rst)
      frame_tick && link_config.div_sel == 2'h2 && !$changed(link_config) |=>
        !frame_tick [*3] ##1 frame_tick;
  endproperty
  a_div4: assert property (p_div4) else $error("divide by four spacing");

  property p_pin_global;
    @(posedge clock) disable iff (sys_rst)
      pdn_s && !pin_is_standby |=> global_power_down && (standby == $past(
        power_down_control[qlt_pkg::PD_STANDBY_BIT]));
  endproperty
  a_pin_global: assert property (p_pin_global) else $error("pin mode wrong");

  property p_dither_write;
    @(posedge clock) disable iff (sys_rst)
      write_en && word[21:8] == qlt_pkg::ADDR_DITHER_OFF |=> channel_dither_off == $past(word[3:0]);
  endproperty
  a_dither_write: assert property (p_dither_write) else $error("dither bits lost");

  property p_clock_pattern;
    @(posedge clock) disable iff (sys_rst)
      state == qlt_pkg::LINK_DATA && frame_tick && !sync_s && !global_power_down &&
      pattern == qlt_pkg::PATTERN_CLOCK && !link_config.scramble_en |=>
        lane_code[0] == {2{10'b0101011010}};
  endproperty
  a_clock_pattern: assert property (p_clock_pattern) else $error("clock pattern wrong");

  property p_ila_start;
    @(posedge clock) disable iff (sys_rst)
      state == qlt_pkg::LINK_ALIGN && frame_idx == 5'h00 && frame_tick &&
      !global_power_down |=>
        lane_code[0][19:10] inside {10'b0011110100, 10'b1100001011};
  endproperty
  a_ila_start: assert property (p_ila_start) else $error("frame start missing");

  // Only checked at the default multiframe length, where the boundary is 16 frames away.
  property p_sysref_align;
    @(posedge clock) disable iff (sys_rst)
      realign && link_config.div_sel == qlt_pkg::DIV_BY_1 &&
      frames_m1 == qlt_pkg::FRAMES_M1_RESET |-> ##16 lmfc_end;
  endproperty
  a_sysref_align: assert property (p_sysref_align) else $error("multiframe late");

endmodule : qlt_transmitter

/* File: qlt_pkg.sv */
// Constants, register map and carrier types for the quad converter serial link transmitter.
package qlt_pkg;

  // ------------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------------
  localparam logic [13:0] ADDR_POWER_DOWN   = 14'h0015;
  localparam logic [13:0] ADDR_TEST_PATTERN = 14'h002a;
  localparam logic [13:0] ADDR_LINK_CONFIG  = 14'h0030;
  localparam logic [13:0] ADDR_FRAMES_PER_MF = 14'h0031;
  localparam logic [13:0] ADDR_DITHER_OFF   = 14'h0032;
  localparam logic [13:0] ADDR_DRIVE        = 14'h0033;
  localparam logic [13:0] ADDR_LINK_STATUS  = 14'h0034;

  localparam int PD_GLOBAL_BIT      = 0;
  localparam int PD_STANDBY_BIT     = 1;
  localparam int PD_PIN_STANDBY_BIT = 2;
  localparam int PATTERN_MSB        = 7;
  localparam int PATTERN_LSB        = 6;
  localparam int CHANNELS           = 4;

  localparam logic [7:0] POWER_DOWN_RESET   = 8'h00;
  localparam logic [7:0] TEST_PATTERN_RESET = 8'h00;
  localparam logic [7:0] LINK_CONFIG_RESET  = 8'h00;
  localparam logic [4:0] FRAMES_M1_RESET    = 5'h0f;
  localparam logic [3:0] DITHER_OFF_RESET   = 4'h0;
  localparam logic [3:0] DRIVE_RESET        = 4'h0;

  localparam logic [1:0] PATTERN_DATA    = 2'h0;
  localparam logic [1:0] PATTERN_CLOCK   = 2'h1;
  localparam logic [1:0] PATTERN_ENCODED = 2'h2;
  localparam logic [1:0] PATTERN_PRBS    = 2'h3;

  localparam logic [1:0] DIV_BY_1 = 2'h0;
  localparam logic [1:0] DIV_BY_2 = 2'h1;

  // ------------------------------------------------------------------------
  // Link symbols and sequencing
  // ------------------------------------------------------------------------
  localparam logic [7:0] K28_0        = 8'h1c;
  localparam logic [7:0] K28_3        = 8'h7c;
  localparam logic [7:0] K28_4        = 8'h9c;
  localparam logic [7:0] K28_5        = 8'hbc;
  localparam logic [7:0] CLOCK_OCTET  = 8'haa;
  localparam logic [1:0] ALIGN_LAST_MF = 2'h3;
  localparam logic [1:0] CONFIG_MF     = 2'h1;
  localparam logic [14:0] PRBS_SEED    = 15'h7fff;
  localparam logic [14:0] SCRAMBLE_SEED = 15'h0000;

  localparam logic [4:0] SERIAL_LAST_BIT = 5'h17;
  localparam logic [4:0] SERIAL_ADDR_END = 5'h0f;

  typedef enum {LINK_COMMA, LINK_WAIT_LMFC, LINK_ALIGN, LINK_DATA} qlt_link_state_type;

  typedef struct packed {
    logic       pad;
    logic       pad2;
    logic [1:0] div_sel;
    logic [1:0] subclass;
    logic       mode40;
    logic       scramble_en;
  } qlt_link_cfg_type;

  typedef struct packed {
    logic       is_k;
    logic [7:0] octet;
  } qlt_symbol_type;

endpackage : qlt_pkg

/* File: qlt_link_partner.sv */
// Receiver model that drives the sync request and watches lane 0.
`timescale 1ns/10ps
module qlt_link_partner (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        resync,
  input  wire logic        valid,
  input  wire logic [19:0] code,
  output logic             sync_request,
  output logic [7:0]       bad_cnt
);
  logic [3:0] run;
  logic       comma;
  // Either running disparity of the comma counts, since the start disparity may differ.
  assign comma = (code[19:10] == 10'h0fa || code[19:10] == 10'h305)
                 && (code[9:0] == 10'h0fa || code[9:0] == 10'h305);
  always_ff @(posedge clock) begin
    if (sys_rst || resync) begin
      sync_request <= 1'b1;
      run <= 4'h0;
    end else if (valid && sync_request) begin
      run <= comma ? run + 4'h1 : 4'h0;
      if (run == 4'h7 && comma) sync_request <= 1'b0;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) bad_cnt <= 8'h00;
    else if (valid && sync_request && !comma) bad_cnt <= bad_cnt + 8'h01;
  end
endmodule : qlt_link_partner

/* File: test_quad_adc_serial_link_transmitter.sv */
// Self-checking testbench for the quad converter serial link transmitter.
`timescale 1ns/10ps
module test_quad_adc_serial_link_transmitter;
  logic             clock = 1'b0;
  logic             sys_rst = 1'b1;
  logic             serial_enable_n = 1'b1;
  logic             serial_clock = 1'b0;
  logic             serial_data_in = 1'b0;
  logic             power_down_pin = 1'b0;
  logic             resync = 1'b0;
  logic             sysref = 1'b0;
  logic             sdo, sdo_oe, sync_request, frame_tick, valid, gpd, standby, st;
  logic [3:0][19:0] lane_code;
  logic [3:0]       dither_off, drive;
  logic [7:0]       bad_cnt, n;
  int               error_cnt = 0;
  int               n_compared = 0;
  always #50 clock = ~clock;
  qlt_transmitter u_dut (.clock(clock), .sys_rst(sys_rst), .serial_enable_n(serial_enable_n),
    .serial_clock(serial_clock), .serial_data_in(serial_data_in), .serial_data_out(sdo),
    .serial_data_out_oe(sdo_oe), .power_down_pin(power_down_pin),
    .sync_request(sync_request), .sysref(sysref), .sample_in({4{12'h5a3}}), .sample_tick(st),
    .frame_tick(frame_tick), .lane_code(lane_code), .lane_code_valid(valid),
    .global_power_down(gpd), .standby(standby), .channel_dither_off(dither_off),
    .lane_drive_current(drive));
  qlt_link_partner u_rx (.clock(clock), .sys_rst(sys_rst), .resync(resync), .valid(valid),
    .code(lane_code[0]), .sync_request(sync_request), .bad_cnt(bad_cnt));
  // ----------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------
  task end_sim;
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Half period of six clocks keeps the serial clock well under a quarter of the clock.
  task xfer(input logic [23:0] w, output logic [7:0] rd);
    rd = 8'h00;
    serial_enable_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      serial_data_in = w[i];
      repeat (6) @(negedge clock);
      if (i < 8) rd = {rd[6:0], sdo};
      serial_clock = 1'b1;
      repeat (6) @(negedge clock);
      serial_clock = 1'b0;
    end
    repeat (6) @(negedge clock);
    serial_enable_n = 1'b1;
    repeat (6) @(negedge clock);
  endtask : xfer
  task wr(input logic [13:0] a, input logic [7:0] d);
    xfer({2'b01, a, d}, n);
  endtask : wr
  task rdc(input logic [13:0] a, input logic [7:0] exp);
    xfer({2'b11, a, 8'h00}, n);
    check(n, exp, "register");
  endtask : rdc
  task gap(output logic [7:0] c);
    c = 8'h00;
    for (int i = 0; i < 20 && !frame_tick; i++) @(negedge clock);
    do begin
      @(negedge clock);
      c = c + 8'h01;
    end while (!frame_tick && c < 8'h20);
  endtask : gap
  function automatic logic cm(logic [9:0] g);
    return g == 10'h0fa || g == 10'h305;
  endfunction : cm
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (10) @(negedge clock);
    sys_rst = 1'b0;
    for (int i = 0; i < 500 && sync_request; i++) @(negedge clock);
    if (sync_request !== 1'b0) begin
      error_cnt++;
      end_sim();
    end
    check(bad_cnt, 8'h00, "non-comma frames");
    repeat (200) @(negedge clock);
    check({7'h0, cm(lane_code[0][19:10])}, 8'h00, "data after alignment");
    check({7'h0, lane_code[0][19:10] === 10'h165}, 8'h01, "sample code");
    check({7'h0, lane_code[3] === lane_code[0]}, 8'h01, "lane copy");
    resync = 1'b1;
    @(negedge clock);
    resync = 1'b0;
    repeat (8) @(negedge clock);
    check({7'h0, cm(lane_code[0][19:10])}, 8'h01, "comma on resync");
    rdc(qlt_pkg::ADDR_POWER_DOWN, qlt_pkg::POWER_DOWN_RESET);
    rdc(qlt_pkg::ADDR_FRAMES_PER_MF, {3'h0, qlt_pkg::FRAMES_M1_RESET});
    rdc(14'h007f, 8'h00);
    check({4'h0, dither_off}, 8'h00, "dither default");
    wr(qlt_pkg::ADDR_DITHER_OFF, 8'h05);
    check({4'h0, dither_off}, 8'h05, "dither off");
    wr(qlt_pkg::ADDR_DRIVE, 8'h0f);
    check({4'h0, drive}, 8'h0f, "drive");
    for (int p = 0; p < 4; p++) begin
      wr(qlt_pkg::ADDR_TEST_PATTERN, {p[1:0], 6'h00});
      rdc(qlt_pkg::ADDR_TEST_PATTERN, {p[1:0], 6'h00});
    end
    power_down_pin = 1'b1;
    repeat (6) @(negedge clock);
    check({6'h0, gpd, standby}, 8'h02, "pin global");
    wr(qlt_pkg::ADDR_POWER_DOWN, 8'h04);
    check({6'h0, gpd, standby}, 8'h01, "pin standby");
    power_down_pin = 1'b0;
    wr(qlt_pkg::ADDR_POWER_DOWN, 8'h01);
    check({6'h0, gpd, valid}, 8'h02, "register power down");
    wr(qlt_pkg::ADDR_POWER_DOWN, 8'h00);
    wr(qlt_pkg::ADDR_LINK_CONFIG, 8'h02);
    n = {7'h0, st};
    @(negedge clock);
    check({6'h0, n[0], st}, 8'h01 << n[0], "40x sample slots");
    wr(qlt_pkg::ADDR_LINK_CONFIG, 8'h04);
    sysref = 1'b1;
    repeat (30) @(negedge clock);
    sysref = 1'b0;
    for (int d = 0; d < 3; d++) begin
      wr(qlt_pkg::ADDR_LINK_CONFIG, {2'h0, d[1:0], 4'h0});
      gap(n);
      check(n, 8'h01 << d, "frame spacing");
      check({7'h0, st}, 8'h01, "sample tick");
    end
    end_sim();
  end
endmodule : test_quad_adc_serial_link_transmitter
